//--- evt_pkg.sv
// Constants, state codes and contract list for the exception vector map
// Contract
// - Table word 0 holds stack pointer, then one 32-bit handler word per exception.
// - Vector lives at base plus four times vector number; tick is 15, IRQ 16+.
// - Peripheral numbers 0..29 map to vectors; 9 and 13 reserved; last at 0xb4.
// - All programmable priorities come out of reset as zero.
// - After reset, vectors are fetched from a table based at address zero.
// - Only privileged writes move the base, range 0x100 to 0x3fffff00.
// - Faults are hard/memory/usage/bus; system adds NMI, pend, call, tick; IRQs use ISRs.
// - On reset load stack pointer from entry zero, then start at entry one.
package evt_pkg;
   localparam int          VEC_W       = 6;
   localparam int          ADDR_W      = 32;
   localparam int          PRI_W       = 3;
   localparam int          HPRI_W      = 4;
   localparam logic [5:0]  VEC_SP      = 6'h00;
   localparam logic [5:0]  VEC_RESET   = 6'h01;
   localparam logic [5:0]  VEC_NMI     = 6'h02;
   localparam logic [5:0]  VEC_HARD    = 6'h03;
   localparam logic [5:0]  VEC_MEM     = 6'h04;
   localparam logic [5:0]  VEC_USAGE   = 6'h06;
   localparam logic [5:0]  VEC_SVC     = 6'h0b;
   localparam logic [5:0]  VEC_DEBUG   = 6'h0c;
   localparam logic [5:0]  VEC_RSV_HI  = 6'h0d;
   localparam logic [5:0]  VEC_PENDABLE_SERVICE_REQUEST  = 6'h0e;
   localparam logic [5:0]  VEC_TICK    = 6'h0f;
   localparam logic [5:0]  VEC_IRQ0    = 6'h10;
   localparam logic [5:0]  VEC_LAST    = 6'h2d;
   localparam logic [5:0]  IRQ_LAST    = 6'h1d;
   localparam logic [5:0]  IRQ_RSV_A   = 6'h09;
   localparam logic [5:0]  IRQ_RSV_B   = 6'h0d;
   localparam logic [31:0] IRQ_OFS     = 32'h0000_0040;
   localparam logic [31:0] SLOT_BYTES  = 32'h0000_0004;
   localparam logic [31:0] BASE_RESET  = 32'h0000_0000;
   localparam logic [31:0] BASE_MIN    = 32'h0000_0100;
   localparam logic [31:0] BASE_MAX    = 32'h3fff_ff00;
   localparam logic [31:0] BASE_MASK   = 32'hffff_ff00;
   localparam logic [2:0]  PRI_RESET   = 3'h0;
   localparam logic [3:0]  PRI_FIX_RST = 4'hd;
   localparam logic [3:0]  PRI_FIX_NMI = 4'he;
   localparam logic [3:0]  PRI_FIX_HF  = 4'hf;

   typedef enum logic [4:0]
   {
      ST_BOOT    = 5'b00001,
      ST_SP_WAIT = 5'b00010,
      ST_PC_WAIT = 5'b00100,
      ST_IDLE    = 5'b01000,
      ST_VEC_WAIT= 5'b10000
   } evt_state_t;
endpackage

//--- evt_vec_decode.sv
// Vector number decode: slot offset and handler class
`timescale 1ns/10ps
module evt_vec_decode
(
   input  wire logic [evt_pkg::VEC_W-1:0]  vec_sel,     // Exception or peripheral number
   input  wire logic                       vec_irq,     // Number is a peripheral number
   output logic      [evt_pkg::VEC_W-1:0]  vec_num,     // Resulting vector number
   output logic                            vec_ok,      // Vector is implemented
   output logic                            vec_fault,   // Fault class
   output logic                            vec_system,  // System class
   output logic                            vec_isr,     // Peripheral class
   output logic      [evt_pkg::ADDR_W-1:0] vec_offset   // Byte offset in the table
);
   import evt_pkg::*;

   always_comb
   begin
      vec_num = vec_irq ? 6'(vec_sel + VEC_IRQ0) : vec_sel;
      vec_ok = (vec_num <= VEC_LAST) && !(vec_num > VEC_USAGE && vec_num < VEC_SVC)
               && (vec_num != VEC_RSV_HI)
               && (vec_num != 6'(VEC_IRQ0 + IRQ_RSV_A))
               && (vec_num != 6'(VEC_IRQ0 + IRQ_RSV_B))
               && !(vec_irq && vec_sel > IRQ_LAST);
      vec_fault  = (vec_num >= VEC_HARD) && (vec_num <= VEC_USAGE);
      vec_system = ((vec_num >= VEC_NMI) && (vec_num <= VEC_USAGE)) || (vec_num == VEC_SVC)
                   || (vec_num == VEC_PENDABLE_SERVICE_REQUEST) || (vec_num == VEC_TICK);
      vec_isr    = (vec_num >= VEC_IRQ0);
      vec_offset = {24'h00_0000, vec_num, 2'b00};
   end
endmodule

//--- evt_vector_map.sv
// Exception vector map: table base, boot fetch, vector fetch, priorities
`timescale 1ns/10ps
module evt_vector_map
(
   input  wire logic                        clock,        // Core clock
   input  wire logic                        reset,        // Async reset, high
   input  wire logic                        vtor_wr,      // Table base write strobe
   input  wire logic                        vtor_priv,    // Write is privileged
   input  wire logic [evt_pkg::ADDR_W-1:0]  vtor_wdata,   // New table base
   output logic      [evt_pkg::ADDR_W-1:0]  vtor_rdata,   // Current table base
   output logic                             vtor_err,     // Write refused, pulse
   input  wire logic                        pri_wr,       // Priority write strobe
   input  wire logic [evt_pkg::VEC_W-1:0]   pri_idx,      // Vector number to set
   input  wire logic [evt_pkg::PRI_W-1:0]   pri_wdata,    // Priority value
   input  wire logic                        vec_req,      // Vector lookup request
   input  wire logic                        vec_irq,      // vec_sel is a peripheral number
   input  wire logic [evt_pkg::VEC_W-1:0]   vec_sel,      // Exception or peripheral number
   output logic                             vec_err,      // Lookup refused, pulse
   output logic                             busy,         // Not ready for a request
   output logic                             mem_req,      // Table read, pulse
   output logic      [evt_pkg::ADDR_W-1:0]  mem_addr,     // Table read address
   input  wire logic [evt_pkg::ADDR_W-1:0]  mem_rdata,    // Table read data
   input  wire logic                        mem_rvalid,   // Table read data valid
   output logic      [evt_pkg::ADDR_W-1:0]  sp_value,     // Initial stack pointer
   output logic                             sp_load,      // Stack pointer loaded, pulse
   output logic      [evt_pkg::ADDR_W-1:0]  boot_pc,      // Reset handler address
   output logic                             boot_done,    // Boot fetch finished, level
   output logic                             hnd_valid,    // Handler address valid, pulse
   output logic      [evt_pkg::ADDR_W-1:0]  hnd_addr,     // Handler start address
   output logic      [evt_pkg::VEC_W-1:0]   hnd_vec,      // Vector number of lookup
   output logic                             hnd_fault,    // Fault handler
   output logic                             hnd_system,   // System handler
   output logic                             hnd_isr,      // Interrupt service routine
   output logic      [evt_pkg::HPRI_W-1:0]  hnd_pri,      // Signed priority of vector
   output logic                             hnd_lsb_err   // Handler bit zero clear
);
   import evt_pkg::*;

   evt_state_t         state_reg;
   logic [ADDR_W-1:0]  vtor_reg;
   logic [VEC_W-1:0]   dec_num;
   logic               dec_ok;
   logic               dec_fault;
   logic               dec_system;
   logic               dec_isr;
   logic [ADDR_W-1:0]  dec_offset;
   logic [ADDR_W-1:0]  vtor_next;
   logic [PRI_W-1:0]   pri_mem [0:VEC_LAST];
   logic               take_req;

   evt_vec_decode u_decode
   (
      .vec_sel    (vec_sel),
      .vec_irq    (vec_irq),
      .vec_num    (dec_num),
      .vec_ok     (dec_ok),
      .vec_fault  (dec_fault),
      .vec_system (dec_system),
      .vec_isr    (dec_isr),
      .vec_offset (dec_offset)
   );

   assign take_req  = (state_reg == ST_IDLE) && vec_req;
   assign vtor_next = vtor_wdata & BASE_MASK;

   // ==========================================================
   // Table base register
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         vtor_reg <= BASE_RESET;
         vtor_err <= 1'b0;
      end
      else
      begin
         vtor_err <= 1'b0;
         if (vtor_wr)
         begin
            if (vtor_priv && vtor_next >= BASE_MIN && vtor_next <= BASE_MAX)
               vtor_reg <= vtor_next;
            else
               vtor_err <= 1'b1;
         end
      end
   end

   assign vtor_rdata = vtor_reg;

   // ==========================================================
   // Priority store, one entry per vector
   genvar gi;
   generate
      for (gi = 0; gi <= int'(VEC_LAST); gi++)
      begin : g_pri
         localparam bit PROG = (gi >= int'(VEC_MEM) && gi <= int'(VEC_USAGE))
                               || gi == int'(VEC_SVC) || gi == int'(VEC_DEBUG)
                               || (gi >= int'(VEC_PENDABLE_SERVICE_REQUEST)
                                   && gi != int'(VEC_IRQ0 + IRQ_RSV_A)
                                   && gi != int'(VEC_IRQ0 + IRQ_RSV_B));
         always_ff @(posedge clock or posedge reset)
         begin
            if (reset)
               pri_mem[gi] <= PRI_RESET;
            else if (PROG && pri_wr && pri_idx == 6'(gi))
               pri_mem[gi] <= pri_wdata;
         end
      end
   endgenerate

   // ==========================================================
   // Fetch sequencer
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= ST_BOOT;
         mem_req   <= 1'b0;
         mem_addr  <= BASE_RESET;
         sp_value  <= '0;
         sp_load   <= 1'b0;
         boot_pc   <= '0;
         boot_done <= 1'b0;
         busy      <= 1'b1;
         vec_err   <= 1'b0;
         hnd_valid <= 1'b0;
         hnd_addr  <= '0;
         hnd_lsb_err <= 1'b0;
      end
      else
      begin
         mem_req   <= 1'b0;
         sp_load   <= 1'b0;
         vec_err   <= 1'b0;
         hnd_valid <= 1'b0;
         case (state_reg)
            ST_BOOT:
            begin
               mem_req   <= 1'b1;
               mem_addr  <= BASE_RESET + {24'h00_0000, VEC_SP, 2'b00};
               state_reg <= ST_SP_WAIT;
            end
            ST_SP_WAIT:
               if (mem_rvalid)
               begin
                  sp_value  <= mem_rdata;
                  sp_load   <= 1'b1;
                  mem_req   <= 1'b1;
                  mem_addr  <= BASE_RESET + {24'h00_0000, VEC_RESET, 2'b00};
                  state_reg <= ST_PC_WAIT;
               end
            ST_PC_WAIT:
               if (mem_rvalid)
               begin
                  boot_pc   <= mem_rdata;
                  boot_done <= 1'b1;
                  busy      <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            ST_IDLE:
               if (vec_req)
               begin
                  if (dec_ok)
                  begin
                     mem_req   <= 1'b1;
                     mem_addr  <= vtor_reg + dec_offset;
                     busy      <= 1'b1;
                     state_reg <= ST_VEC_WAIT;
                  end
                  else
                     vec_err <= 1'b1;
               end
            ST_VEC_WAIT:
               if (mem_rvalid)
               begin
                  hnd_addr    <= mem_rdata;
                  // Flag a handler without bit zero
                  hnd_lsb_err <= ~mem_rdata[0];
                  hnd_valid   <= 1'b1;
                  busy        <= 1'b0;
                  state_reg   <= ST_IDLE;
               end
            default:
               state_reg <= ST_BOOT;
         endcase
      end
   end

   // ==========================================================
   // Lookup attributes, captured when a valid request is taken
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         hnd_vec    <= '0;
         hnd_fault  <= 1'b0;
         hnd_system <= 1'b0;
         hnd_isr    <= 1'b0;
         hnd_pri    <= '0;
      end
      else if (take_req && dec_ok)
      begin
         hnd_vec    <= dec_num;
         hnd_fault  <= dec_fault;
         hnd_system <= dec_system;
         hnd_isr    <= dec_isr;
         case (dec_num)
            VEC_RESET: hnd_pri <= PRI_FIX_RST;
            VEC_NMI:   hnd_pri <= PRI_FIX_NMI;
            VEC_HARD:  hnd_pri <= PRI_FIX_HF;
            default:   hnd_pri <= {1'b0, pri_mem[dec_num]};
         endcase
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence s_boot_sp;
      mem_req && mem_addr == BASE_RESET;
   endsequence

   sequence s_boot_pc;
      mem_req && sp_load && mem_addr == (BASE_RESET + SLOT_BYTES);
   endsequence

   AST_BOOT_SP: assert property (state_reg == ST_BOOT |=> s_boot_sp)
      else $error("first boot read not at table word zero");
   AST_BOOT_PC: assert property (state_reg == ST_SP_WAIT && mem_rvalid |=> s_boot_pc)
      else $error("reset entry not read after stack pointer");
   AST_SLOT_WORD: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
      else $error("table read not word aligned");
   AST_VEC_ADDR: assert property
      (take_req && dec_ok |=> mem_req
       && mem_addr == $past(vtor_reg) + {$past(dec_num), 2'b00})
      else $error("vector address not base plus four times number");
   AST_IRQ_ADDR: assert property
      (take_req && vec_irq && dec_ok |=>
       mem_addr == $past(vtor_reg) + IRQ_OFS + {$past(vec_sel), 2'b00})
      else $error("peripheral vector address wrong");
   AST_IRQ_RSV: assert property
      (take_req && vec_irq && (vec_sel == IRQ_RSV_A || vec_sel == IRQ_RSV_B
       || vec_sel > IRQ_LAST) |=> vec_err && !mem_req)
      else $error("reserved peripheral vector not refused");
   AST_VTOR_PRIV: assert property (vtor_wr && !vtor_priv |=> $stable(vtor_reg) && vtor_err)
      else $error("unprivileged write moved table base");
   AST_VTOR_RANGE: assert property
      (vtor_reg == BASE_RESET || (vtor_reg >= BASE_MIN && vtor_reg <= BASE_MAX))
      else $error("table base out of range");
   AST_VTOR_ALIGN: assert property (vtor_reg[7:0] == 8'h00)
      else $error("table base not 256 byte aligned");
   AST_PRI_RESET: assert property
      (state_reg == ST_BOOT |-> pri_mem[VEC_TICK] == PRI_RESET
       && pri_mem[VEC_PENDABLE_SERVICE_REQUEST] == PRI_RESET && pri_mem[VEC_IRQ0] == PRI_RESET)
      else $error("priority not zero after reset");
   AST_CLASS: assert property (hnd_valid && hnd_fault |-> hnd_system && !hnd_isr)
      else $error("fault not classed as system");
endmodule

//--- evt_table_mem.sv
// Vector table memory model answering table reads
`timescale 1ns/10ps
module evt_table_mem
(
   input  wire logic        clock,       // Core clock
   input  wire logic        reset,       // Async reset, high
   input  wire logic        mem_req,     // Table read, pulse
   input  wire logic [31:0] mem_addr,    // Table read address
   input  wire logic [3:0]  lag,         // Extra answer cycles
   input  wire logic        bad_en,      // Clear handler bit zero
   output logic      [31:0] mem_rdata,   // Table read data
   output logic             mem_rvalid   // Read data valid
);
   logic [31:0] addr_reg;
   logic [3:0]  wait_reg;
   logic        pend_reg;
   function automatic logic [31:0] slot_word(input logic [31:0] a, input logic bad);
      slot_word = ({a[27:0], 4'h0} ^ 32'h0800_0001) & ~{31'h0, bad};
   endfunction
   // One answer per read; data line toggles when idle
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         pend_reg   <= 1'b0;
         wait_reg   <= 4'h0;
         addr_reg   <= 32'h0;
         mem_rvalid <= 1'b0;
         mem_rdata  <= 32'h0;
      end
      else
      begin
         mem_rvalid <= 1'b0;
         mem_rdata  <= ~mem_rdata;
         if (mem_req)
         begin
            pend_reg <= 1'b1;
            addr_reg <= mem_addr;
            wait_reg <= lag;
         end
         else if (pend_reg && wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
         else if (pend_reg)
         begin
            pend_reg   <= 1'b0;
            mem_rvalid <= 1'b1;
            mem_rdata  <= slot_word(addr_reg, bad_en);
         end
      end
   end
endmodule

//--- test_exception_vector_table_map.sv
// Self-checking bench for the exception vector map
`timescale 1ns/10ps
module test_exception_vector_table_map;
   import evt_pkg::*;
   logic        clock, reset, vtor_wr, vtor_priv, vtor_err, pri_wr, vec_req, vec_irq;
   logic        vec_err, busy, mem_req, mem_rvalid, sp_load, boot_done, hnd_valid;
   logic        hnd_fault, hnd_system, hnd_isr, hnd_lsb_err, bad_en;
   logic [31:0] vtor_wdata, vtor_rdata, mem_addr, mem_rdata, sp_value, boot_pc, hnd_addr;
   logic [31:0] base_exp;
   logic [5:0]  pri_idx, vec_sel, hnd_vec;
   logic [2:0]  pri_wdata;
   logic [3:0]  hnd_pri, lag;
   int          mismatches, checks, n;
   evt_vector_map uut (.clock(clock), .reset(reset), .vtor_wr(vtor_wr), .vtor_priv(vtor_priv),
      .vtor_wdata(vtor_wdata), .vtor_rdata(vtor_rdata), .vtor_err(vtor_err), .pri_wr(pri_wr),
      .pri_idx(pri_idx), .pri_wdata(pri_wdata), .vec_req(vec_req), .vec_irq(vec_irq),
      .vec_sel(vec_sel), .vec_err(vec_err), .busy(busy), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
      .sp_value(sp_value), .sp_load(sp_load), .boot_pc(boot_pc), .boot_done(boot_done),
      .hnd_valid(hnd_valid), .hnd_addr(hnd_addr), .hnd_vec(hnd_vec), .hnd_fault(hnd_fault),
      .hnd_system(hnd_system), .hnd_isr(hnd_isr), .hnd_pri(hnd_pri), .hnd_lsb_err(hnd_lsb_err));
   evt_table_mem mem (.clock(clock), .reset(reset), .mem_req(mem_req), .mem_addr(mem_addr),
      .lag(lag), .bad_en(bad_en), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // ==========================================
   // Shared tasks
   function automatic logic [31:0] word_at(input logic [31:0] a);
      word_at = {a[27:0], 4'h0} ^ 32'h0800_0001;
   endfunction
   task complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wait_for(input int which);
      int i;
      i = 0;
      while (((which == 0) ? boot_done : (which == 1) ? ~busy
              : (which == 2) ? hnd_valid : sp_load) !== 1'b1 && i < 60)
      begin
         @(posedge clock);
         #1;
         i++;
      end
      if (i == 60)
      begin
         mismatches++;
         complete_run;
      end
   endtask
   task lookup(input logic irq, input logic [5:0] sel, input logic [5:0] vec,
               input logic [2:0] cls, input logic [3:0] pri, input logic ok);
      logic [31:0] a;
      a = base_exp + {24'h0, vec, 2'b00};
      wait_for(1);
      vec_req = 1'b1;
      vec_irq = irq;
      vec_sel = sel;
      @(posedge clock);
      #1;
      vec_req = 1'b0;
      check(vec_err, !ok);
      check({mem_req, busy}, {ok, ok});
      if (ok)
      begin
         check(mem_addr, a);
         check(hnd_vec, vec);
         check({hnd_fault, hnd_system, hnd_isr}, cls);
         check(hnd_pri, pri);
         wait_for(2);
         check(hnd_addr, word_at(a) & ~{31'h0, bad_en});
         check(hnd_lsb_err, bad_en);
      end
      else
      begin
         // Refusal is a one-cycle pulse
         @(posedge clock);
         #1;
         check(vec_err, 1'b0);
      end
   endtask
   task wr_base(input logic priv, input logic [31:0] d, input logic ok);
      vtor_wr = 1'b1;
      vtor_priv = priv;
      vtor_wdata = d;
      @(posedge clock);
      #1;
      if (ok)
         base_exp = d & BASE_MASK;
      check(vtor_err, !ok);
      check(vtor_rdata, base_exp);
   endtask
   task pri_write(input logic [5:0] idx, input logic [2:0] val);
      pri_wr = 1'b1;
      pri_idx = idx;
      pri_wdata = val;
      @(posedge clock);
      #1;
   endtask
   // ==========================================
   // Scenarios
   task run_reset_boot(input logic [3:0] slow);
      lag = slow;
      reset = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      reset = 1'b0;
      base_exp = BASE_RESET;
      @(posedge clock);
      #1;
      check({mem_req, busy, boot_done}, 3'b110);
      check(mem_addr, BASE_RESET);
      wait_for(3);
      check({sp_load, mem_req}, 2'b11);
      check(mem_addr, SLOT_BYTES);
      check(sp_value, word_at(32'h0));
      wait_for(0);
      check(boot_pc, word_at(32'h4));
      check(vtor_rdata, BASE_RESET);
   endtask
   task run_system;
      lookup(0, VEC_RESET, VEC_RESET, 3'b000, PRI_FIX_RST, 1);
      lookup(0, VEC_NMI, VEC_NMI, 3'b010, PRI_FIX_NMI, 1);
      lookup(0, VEC_HARD, VEC_HARD, 3'b110, PRI_FIX_HF, 1);
      for (n = 4; n < 16; n++)
         lookup(0, n, n, (n < 7) ? 3'b110 : (n == 12) ? 3'b000 : 3'b010, 4'h0,
                n < 7 || n == 11 || n == 12 || n > 13);
      lookup(0, 6'h2e, 6'h2e, 3'b000, 4'h0, 0);
   endtask
   task run_irq;
      for (n = 0; n < 31; n++)
         lookup(1, n, n + 16, 3'b001, 4'h0, n != 9 && n != 13 && n < 30);
   endtask
   task run_priority;
      pri_write(VEC_TICK, 3'h5);
      pri_write(VEC_IRQ0, 3'h7);
      pri_write(VEC_NMI, 3'h3);
      pri_wr = 1'b0;
      lookup(0, VEC_TICK, VEC_TICK, 3'b010, 4'h5, 1);
      lookup(1, 6'h0, VEC_IRQ0, 3'b001, 4'h7, 1);
      lookup(0, VEC_NMI, VEC_NMI, 3'b010, PRI_FIX_NMI, 1);
   endtask
   task run_relocate;
      wr_base(0, 32'h0000_2000, 0);
      wr_base(1, 32'h0000_00ff, 0);
      wr_base(1, BASE_MIN, 1);
      wr_base(1, BASE_MAX, 1);
      wr_base(1, 32'h4000_0000, 0);
      wr_base(1, 32'h0000_2055, 1);
      vtor_wr = 1'b0;
      lookup(1, 6'h2, 6'h12, 3'b001, 4'h0, 1);
      bad_en = 1'b1;
      lookup(0, VEC_TICK, VEC_TICK, 3'b010, 4'h5, 1);
      bad_en = 1'b0;
   endtask
   task run_after_reset;
      lookup(0, VEC_TICK, VEC_TICK, 3'b010, 4'h0, 1);
      lookup(1, IRQ_LAST, VEC_LAST, 3'b001, 4'h0, 1);
   endtask
   initial
   begin
      reset = 1'b1;
      {vtor_wr, vtor_priv, pri_wr, vec_req, vec_irq, bad_en} = 6'h0;
      {vtor_wdata, pri_idx, pri_wdata, vec_sel, lag} = 51'h0;
      mismatches = 0;
      checks = 0;
      base_exp = 32'h0;
      @(posedge clock);
      #1;
      run_reset_boot(4'h3);
      run_system;
      run_irq;
      run_priority;
      run_relocate;
      run_reset_boot(4'h1);
      run_after_reset;
      complete_run;
   end
endmodule
